// *** hw/pmrs_counter.sv ***
// Down-counter with load and expiry pulse
`timescale 1ns/1ps
module pmrs_counter
   import pmrs_pkg::*;
#(
   parameter int unsigned WIDTH = 10
)(
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   input  wire logic             enable,
   output logic                  running,
   output logic                  expired
);

   initial
   begin
      if (WIDTH < 2) $error("pmrs_counter WIDTH too small");
   end

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             running;
      logic             expired;
   } cnt_state_type;

   cnt_state_type state;
   cnt_state_type next_state;

   always_comb
   begin
      next_state         = state;
      next_state.expired = 1'b0;
      if (load)
      begin
         next_state.count   = load_value;
         next_state.running = 1'b1;
      end
      else if (state.running && enable)
      begin
         if (state.count == '0)
         begin
            next_state.running = 1'b0;
            next_state.expired = 1'b1;
         end
         else
         begin
            next_state.count = state.count - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         state <= '0;
      else
         state <= next_state;
   end

   assign running = state.running;
   assign expired = state.expired;

endmodule : pmrs_counter

// *** hw/pmrs_pkg.sv ***
// Package: constants and carrier types for the power-mode and reset sequencer
package pmrs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS      = 4;
   localparam int unsigned CLOCKS_PER_MCYCLE  = 4;
   localparam int unsigned RESET_HOLD_MCYCLES = 2;
   localparam int unsigned RESET_HOLD_CLOCKS  = RESET_HOLD_MCYCLES * CLOCKS_PER_MCYCLE;
   localparam int unsigned WDT_RESET_DELAY    = 512;
   localparam int unsigned STATE_FOURTH       = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] PC_RESET_VALUE = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_IDLE,
      MODE_POWER_DOWN,
      MODE_RESET
   } mode_type;

   typedef struct packed {
      logic pwr_on;
      logic wdt_reset;
      logic wdt_reset_en;
   } reset_flags_type;

   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic osc_en;
   } clock_gates_type;

endpackage : pmrs_pkg

// *** hw/power_mode_reset_sequencer.sv ***
// Power-mode control, wake-up, reset synchronisation and reset-source flags
// Behaviour
// - Write setting idle is the last instruction before idle begins.
// - Idle gates CPU clock only; peripherals keep clocks; CPU state holds.
// - Idle drives address latch and program fetch strobes high; ports hold levels.
// - Enabled interrupt ends idle, clears idle bit, resumes after entering instruction.
// - Any reset ends idle; PC to zero; next instruction never executes.
// - Watchdog counts in idle; timeout wakes; reset 512 clocks later unless cleared. Here the timeout does not wake; only irq_pending wakes from idle.
// - Setting power-down stops every internal clock after that instruction.
// - Power-down drives both strobes low; ports output their port registers.
// - High reset pin ends power-down, restarts clock, execution from zero.
// - Watchdog cannot end power-down since its clock is stopped.
// - Enabled level-detect external interrupt low wakes power-down into its service.
// - External memory: port 0 floats; port 2 address in idle, data in power-down.
// - Reset pin sampled in fourth clock state of each machine cycle.
// - Reset held while pin high and two machine cycles after release.
// - External reset sets no flag; inferred when both flags clear.
// - Supply brown-out resets; recovery runs power-on delay and sets flag.
// - A machine cycle is four clock periods.
// - Watchdog reset held two machine cycles before execution from zero.
// - Flags: power-on sets own, clears watchdog flag and enable; others keep enable.
`timescale 1ns/1ps
module power_mode_reset_sequencer
   import pmrs_pkg::*;
#(
   parameter int unsigned POR_DELAY_CLOCKS = 64
)(
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   input  wire logic            reset_pin,
   input  wire logic            supply_ok,
   input  wire logic            power_control_register_write,
   input  wire logic            power_control_register_idle_wr,
   input  wire logic            power_control_register_pd_wr,
   input  wire logic            irq_pending,
   input  wire logic [1:0]      ext_int_n,
   input  wire logic [1:0]      ext_int_en,
   input  wire logic [1:0]      ext_int_level,
   input  wire logic            global_interrupt_enable,
   input  wire logic            wdt_timeout,
   input  wire logic            wdt_clear,
   input  wire logic            flag_write,
   input  wire logic            flag_pwr_on_wr,
   input  wire logic            flag_wdt_wr,
   input  wire logic            flag_en_wr,
   input  wire logic            ext_program_mem,
   output clock_gates_type      clocks,
   output logic                 cpu_reset,
   output logic                 pc_load_zero,
   output logic                 idle_bit,
   output logic                 pd_bit,
   output logic                 addr_latch_strobe_force,
   output logic                 program_fetch_strobe_force,
   output logic                 strobe_force_level,
   output logic                 ports_hold,
   output logic                 port0_float,
   output logic                 port2_data_select,
   output reset_flags_type      flags
);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   initial
   begin
      if (POR_DELAY_CLOCKS < 1 || POR_DELAY_CLOCKS > 65535) $error("POR_DELAY_CLOCKS out of range");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rst_meta;
      logic [1:0] sup_meta;
      logic [1:0] int0_meta;
      logic [1:0] int1_meta;
   } sync_type;

   sync_type sync;
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         sync <= '{rst_meta: 2'b00, sup_meta: 2'b00, int0_meta: 2'b11, int1_meta: 2'b11};
      else
         sync <= '{rst_meta: {sync.rst_meta[0], reset_pin}, sup_meta: {sync.sup_meta[0], supply_ok},
                   int0_meta: {sync.int0_meta[0], ext_int_n[0]}, int1_meta: {sync.int1_meta[0], ext_int_n[1]}};
   end

   logic       rst_s;
   logic       sup_s;
   logic [1:0] int_n_s;
   assign rst_s   = sync.rst_meta[1];
   assign sup_s   = sync.sup_meta[1];
   assign int_n_s = {sync.int1_meta[1], sync.int0_meta[1]};

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      mode_type        mode;
      logic [1:0]      phase;
      logic            rst_sampled;
      logic            wdt_armed;
      logic            was_por;
      reset_flags_type flags;
      clock_gates_type clocks;
      logic            cpu_reset;
      logic            pc_load_zero;
      logic            strobe_force;
      logic            strobe_level;
      logic            pd_mode;
      logic            ports_hold;
      logic            port0_float;
      logic            port2_data;
   } seq_state_type;

   seq_state_type state;
   seq_state_type next_state;

   logic hold_load;
   logic hold_running;
   logic hold_done;
   logic wdt_load;
   logic wdt_running;
   logic wdt_fire;
   logic por_load;
   logic por_running;
   logic por_done;
   logic fourth_clock_state;
   logic level_wake;

   assign fourth_clock_state = (state.phase == 2'(STATE_FOURTH));
   assign level_wake = |(~int_n_s & ext_int_en & ext_int_level) && global_interrupt_enable;

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   pmrs_counter #(.WIDTH(4)) u_hold (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .load       (hold_load),
      .load_value (4'(RESET_HOLD_CLOCKS - 1)),
      .enable     (1'b1),
      .running    (hold_running),
      .expired    (hold_done)
   );

   pmrs_counter #(.WIDTH(10)) u_wdt (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .load       (wdt_load),
      .load_value (10'(WDT_RESET_DELAY - 1)),
      .enable     (state.clocks.periph_clk_en),
      .running    (wdt_running),
      .expired    (wdt_fire)
   );

   pmrs_counter #(.WIDTH(16)) u_por (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .load       (por_load),
      .load_value (16'(POR_DELAY_CLOCKS - 1)),
      .enable     (1'b1),
      .running    (por_running),
      .expired    (por_done)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state              = state;
      next_state.phase        = state.phase + 2'd1;
      next_state.pc_load_zero = 1'b0;
      hold_load = 1'b0;
      por_load  = 1'b0;
      wdt_load  = 1'b0;

      if (fourth_clock_state)
         next_state.rst_sampled = rst_s;

      // Watchdog: armed on timeout, disarmed by software clear
      if (wdt_clear)
         next_state.wdt_armed = 1'b0;
      else if (wdt_timeout && state.flags.wdt_reset_en && state.clocks.periph_clk_en)
      begin
         next_state.wdt_armed = 1'b1;
         wdt_load = !state.wdt_armed;
      end

      // Software flag writes; hardware sets below take precedence
      if (flag_write)
      begin
         next_state.flags.pwr_on       = flag_pwr_on_wr;
         next_state.flags.wdt_reset    = flag_wdt_wr;
         next_state.flags.wdt_reset_en = flag_en_wr;
      end

      if (!sup_s)
      begin
         next_state.mode      = MODE_RESET;
         next_state.was_por   = 1'b1;
         next_state.cpu_reset = 1'b1;
         next_state.wdt_armed = 1'b0;
         por_load             = 1'b1;
         next_state.flags     = '{pwr_on: 1'b1, wdt_reset: 1'b0, wdt_reset_en: 1'b0};
      end
      else
      begin
         case (state.mode)
            MODE_RUN, MODE_IDLE:
            begin
               if (state.rst_sampled || (wdt_fire && state.wdt_armed && !wdt_clear))
               begin
                  if (wdt_fire && state.wdt_armed && !state.rst_sampled)
                     next_state.flags.wdt_reset = 1'b1;
                  next_state.mode      = MODE_RESET;
                  next_state.cpu_reset = 1'b1;
                  next_state.was_por   = 1'b0;
                  next_state.wdt_armed = 1'b0;
                  hold_load            = 1'b1;
               end
               else if (state.mode == MODE_IDLE && irq_pending)
                  next_state.mode = MODE_RUN;
               else if (state.mode == MODE_RUN && power_control_register_write && power_control_register_pd_wr)
                  next_state.mode = MODE_POWER_DOWN;
               else if (state.mode == MODE_RUN && power_control_register_write && power_control_register_idle_wr)
                  next_state.mode = MODE_IDLE;
            end
            MODE_POWER_DOWN:
            begin
               // Clock stopped: raw synced pin, no phase sampling possible
               if (rst_s)
               begin
                  next_state.mode      = MODE_RESET;
                  next_state.cpu_reset = 1'b1;
                  hold_load            = 1'b1;
               end
               else if (level_wake)
                  next_state.mode = MODE_RUN;
            end
            MODE_RESET:
            begin
               if (state.rst_sampled || rst_s)
                  hold_load = 1'b1;
               else if (!hold_running && !por_running && !hold_load)
               begin
                  next_state.mode         = MODE_RUN;
                  next_state.cpu_reset    = 1'b0;
                  next_state.pc_load_zero = 1'b1;
               end
               if (por_done)
                  next_state.was_por = 1'b0;
            end
            default:
               next_state.mode = MODE_RESET;
         endcase
      end

      // Clock gates and pin forcing follow the next mode
      next_state.clocks.cpu_clk_en    = (next_state.mode == MODE_RUN) || (next_state.mode == MODE_RESET);
      next_state.clocks.periph_clk_en = (next_state.mode != MODE_POWER_DOWN);
      next_state.clocks.osc_en        = (next_state.mode != MODE_POWER_DOWN);
      next_state.strobe_force = (next_state.mode == MODE_IDLE) || (next_state.mode == MODE_POWER_DOWN);
      next_state.strobe_level = (next_state.mode == MODE_IDLE);
      next_state.pd_mode      = (next_state.mode == MODE_POWER_DOWN);
      next_state.ports_hold   = next_state.strobe_force;
      next_state.port0_float  = next_state.strobe_force && ext_program_mem;
      next_state.port2_data   = !ext_program_mem || (next_state.mode == MODE_POWER_DOWN);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         state              <= '0;
         state.mode         <= MODE_RESET;
         state.cpu_reset    <= 1'b1;
         state.clocks       <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1};
         state.port2_data   <= 1'b1;
      end
      else
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign clocks                     = state.clocks;
   assign cpu_reset                  = state.cpu_reset;
   assign pc_load_zero               = state.pc_load_zero;
   assign idle_bit                   = state.strobe_level;
   assign pd_bit                     = state.pd_mode;
   assign addr_latch_strobe_force    = state.strobe_force;
   assign program_fetch_strobe_force = state.strobe_force;
   assign strobe_force_level         = state.strobe_level;
   assign ports_hold                 = state.ports_hold;
   assign port0_float                = state.port0_float;
   assign port2_data_select          = state.port2_data;
   assign flags                      = state.flags;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_IDLE_CLOCKS: assert property (@(posedge ref_clk) disable iff (!rstn)
      idle_bit |-> !clocks.cpu_clk_en && clocks.periph_clk_en)
      else $error("idle clock gating wrong");
   AST_PD_CLOCKS: assert property (@(posedge ref_clk) disable iff (!rstn)
      pd_bit |-> !clocks.osc_en && !clocks.periph_clk_en)
      else $error("power-down clocks not stopped");
   AST_STROBE_LEVEL: assert property (@(posedge ref_clk) disable iff (!rstn)
      (idle_bit |-> strobe_force_level) and (pd_bit |-> !strobe_force_level))
      else $error("strobe level wrong in low-power mode");
   AST_IDLE_WAKE: assert property (@(posedge ref_clk) disable iff (!rstn)
      idle_bit && irq_pending && !state.rst_sampled && sup_s && !wdt_fire |=> !idle_bit && !cpu_reset)
      else $error("interrupt did not end idle");
   AST_PD_PRIORITY: assert property (@(posedge ref_clk) disable iff (!rstn)
      state.mode == MODE_RUN && power_control_register_write && power_control_register_pd_wr && sup_s && !state.rst_sampled && !wdt_fire
      |=> pd_bit)
      else $error("power-down did not take precedence");
   AST_PD_NO_WDT: assert property (@(posedge ref_clk) disable iff (!rstn)
      pd_bit && !rst_s && sup_s |=> !flags.wdt_reset || $past(flags.wdt_reset))
      else $error("watchdog acted in power-down");
   AST_RESET_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(cpu_reset) && sup_s |-> cpu_reset [*8])
      else $error("reset shorter than two machine cycles");
   AST_POR_FLAGS: assert property (@(posedge ref_clk) disable iff (!rstn)
      !sup_s |=> flags.pwr_on && !flags.wdt_reset && !flags.wdt_reset_en && cpu_reset)
      else $error("power-on flags wrong");
   AST_RESET_PC: assert property (@(posedge ref_clk) disable iff (!rstn)
      $fell(cpu_reset) |-> pc_load_zero)
      else $error("execution did not restart at zero");

endmodule : power_mode_reset_sequencer

// *** tb/pmrs_partner.sv ***
// Partner model: external reset source, interrupt pins and CPU flag writes
`timescale 1ns/1ps
module pmrs_partner
(
   input  wire logic  ref_clk,
   output logic       reset_pin,
   output logic [1:0] ext_int_n,
   output logic       flag_write,
   output logic       flag_pwr_on_wr,
   output logic       flag_wdt_wr,
   output logic       flag_en_wr
);
   initial
   begin
      reset_pin = 1'b0;
      ext_int_n = 2'h3;
      flag_write = 1'b0;
      {flag_pwr_on_wr, flag_wdt_wr, flag_en_wr} = 3'h0;
   end

   // Never shorter than a valid reset, else the pin may be missed
   task pulse_reset(input int n);
      reset_pin = 1'b1;
      repeat ((n < 8) ? 8 : n) @(negedge ref_clk);
      reset_pin = 1'b0;
   endtask : pulse_reset

   task pin_level(input logic [1:0] lvl);
      ext_int_n = lvl;
   endtask : pin_level

   // Software clears the power-on flag once it has been read
   task write_flags(input logic por, input logic wdt, input logic en);
      flag_write = 1'b1;
      {flag_pwr_on_wr, flag_wdt_wr, flag_en_wr} = {por, wdt, en};
      @(negedge ref_clk);
      flag_write = 1'b0;
   endtask : write_flags
endmodule : pmrs_partner

// *** tb/power_mode_reset_sequencer_tb.sv ***
// Testbench for the power-mode and reset sequencer
`timescale 1ns/1ps
module power_mode_reset_sequencer_tb
   import pmrs_pkg::*;
;
   logic            ref_clk, rstn, supply_ok, power_control_register_write, power_control_register_idle_wr, power_control_register_pd_wr;
   logic            irq_pending, gie, wdt_timeout, wdt_clear, ext_program_mem;
   logic [1:0]      ext_int_en, ext_int_level, ext_int_n;
   logic            reset_pin, flag_write, f_por, f_wdt, f_en;
   logic            cpu_reset, pc_load_zero, idle_bit, pd_bit;
   logic            als_f, pfs_f, force_lvl, ports_hold, port0_float, p2_data;
   clock_gates_type clocks;
   reset_flags_type flags;
   int              fails = 0;
   int              checked = 0;
   int              n;

   power_mode_reset_sequencer #(.POR_DELAY_CLOCKS(4)) DUT (
      .ref_clk(ref_clk), .rstn(rstn), .reset_pin(reset_pin), .supply_ok(supply_ok),
      .power_control_register_write(power_control_register_write), .power_control_register_idle_wr(power_control_register_idle_wr), .power_control_register_pd_wr(power_control_register_pd_wr),
      .irq_pending(irq_pending), .ext_int_n(ext_int_n), .ext_int_en(ext_int_en),
      .ext_int_level(ext_int_level), .global_interrupt_enable(gie),
      .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear), .flag_write(flag_write),
      .flag_pwr_on_wr(f_por), .flag_wdt_wr(f_wdt), .flag_en_wr(f_en),
      .ext_program_mem(ext_program_mem), .clocks(clocks), .cpu_reset(cpu_reset),
      .pc_load_zero(pc_load_zero), .idle_bit(idle_bit), .pd_bit(pd_bit),
      .addr_latch_strobe_force(als_f), .program_fetch_strobe_force(pfs_f),
      .strobe_force_level(force_lvl), .ports_hold(ports_hold),
      .port0_float(port0_float), .port2_data_select(p2_data), .flags(flags));

   pmrs_partner partner (
      .ref_clk(ref_clk), .reset_pin(reset_pin), .ext_int_n(ext_int_n),
      .flag_write(flag_write), .flag_pwr_on_wr(f_por), .flag_wdt_wr(f_wdt),
      .flag_en_wr(f_en));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task check(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : check

   function automatic logic pick(input int s);
      case (s)
         0: return cpu_reset;
         1: return pc_load_zero;
         2: return idle_bit;
         default: return pd_bit;
      endcase
   endfunction : pick

   // Bounded poll; n equals lim when the level never came
   task wait_for(input int s, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (pick(s) !== lvl && cnt < lim)
      begin
         @(negedge ref_clk);
         cnt++;
      end
   endtask : wait_for

   task power_control_register(input logic idle, input logic pd);
      power_control_register_write = 1'b1;
      power_control_register_idle_wr = idle;
      power_control_register_pd_wr = pd;
      @(negedge ref_clk);
      power_control_register_write = 1'b0;
      @(negedge ref_clk);
   endtask : power_control_register

   task lp_check(input logic idle);
      check(idle_bit, idle, "idle bit");
      check(pd_bit, !idle, "pd bit");
      check(clocks.cpu_clk_en, 1'b0, "cpu clock");
      check(clocks.periph_clk_en, idle, "periph clock");
      check(clocks.osc_en, idle, "oscillator");
      check(als_f & pfs_f, 1'b1, "strobe force");
      check(force_lvl, idle, "strobe level");
      check(port0_float, ext_program_mem, "port0 float");
      check(p2_data, !(idle && ext_program_mem), "port2 select");
   endtask : lp_check

   // Selected by number: a copied-out argument would only ever show the final low
   task pulse(input int s);
      {irq_pending, wdt_timeout, wdt_clear} = 3'h4 >> s;
      @(negedge ref_clk);
      {irq_pending, wdt_timeout, wdt_clear} = 3'h0;
   endtask : pulse

   task pin_reset;
      fork
         partner.pulse_reset(8);
         wait_for(0, 1'b1, 8, n);
      join
      check(n < 8, 1'b1, "pin reset late");
      check(idle_bit | pd_bit, 1'b0, "mode kept");
      wait_for(0, 1'b0, 16, n);
      check(n < 16, 1'b1, "reset stuck");
      wait_for(1, 1'b1, 4, n);
      check(pc_load_zero, 1'b1, "no pc zero");
      @(negedge ref_clk);
      check(pc_load_zero, 1'b0, "pc zero long");
   endtask : pin_reset

   task results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Tests need about 2000 cycles; ample margin
   initial
   begin
      #200000;
      fails++;
      results();
   end

   initial
   begin
      {rstn, supply_ok, power_control_register_write, power_control_register_idle_wr, power_control_register_pd_wr, irq_pending} = 6'h00;
      {gie, wdt_timeout, wdt_clear, ext_program_mem} = 4'h0;
      ext_int_en = 2'h0;
      ext_int_level = 2'h0;
      repeat (12) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(cpu_reset, 1'b1, "brown-out reset");
      supply_ok = 1'b1;
      wait_for(0, 1'b0, 40, n);
      check(n < 40, 1'b1, "por stuck");
      check(flags.pwr_on, 1'b1, "por flag");
      check(flags.wdt_reset | flags.wdt_reset_en, 1'b0, "por clears");
      partner.write_flags(1'b0, 1'b0, 1'b1);
      @(negedge ref_clk);
      check(flags.pwr_on, 1'b0, "por flag clear");
      // Idle with internal, then external program memory
      for (int m = 0; m < 2; m++)
      begin
         ext_program_mem = m[0];
         power_control_register(1'b1, 1'b0);
         lp_check(1'b1);
         check(ports_hold, 1'b1, "ports hold");
         pulse(0);
         check(idle_bit, 1'b0, "irq wake");
         check(clocks.cpu_clk_en, 1'b1, "cpu clock back");
      end
      // Both bits in one write; wrong wake conditions are refused
      power_control_register(1'b1, 1'b1);
      lp_check(1'b0);
      pulse(1);
      wait_for(0, 1'b1, 600, n);
      check(cpu_reset, 1'b0, "wdt in power-down");
      ext_int_en = 2'h1;
      gie = 1'b1;
      partner.pin_level(2'h2);
      repeat (10) @(negedge ref_clk);
      check(pd_bit, 1'b1, "edge mode woke");
      ext_int_level = 2'h1;
      gie = 1'b0;
      repeat (10) @(negedge ref_clk);
      check(pd_bit, 1'b1, "gie off woke");
      gie = 1'b1;
      wait_for(3, 1'b0, 8, n);
      check(n < 8, 1'b1, "level wake");
      check(cpu_reset, 1'b0, "level wake reset");
      partner.pin_level(2'h3);
      // Reset pin out of power-down
      power_control_register(1'b0, 1'b1);
      pin_reset();
      check(flags.wdt_reset_en, 1'b1, "pin reset en");
      // Watchdog cleared in time: no reset
      power_control_register(1'b1, 1'b0);
      pulse(1);
      repeat (100) @(negedge ref_clk);
      pulse(2);
      wait_for(0, 1'b1, 600, n);
      check(cpu_reset, 1'b0, "cleared wdt reset");
      // Watchdog reset from idle, woken by its own interrupt
      pulse(1);
      pulse(0);
      check(idle_bit, 1'b0, "wdt irq wake");
      wait_for(0, 1'b1, 600, n);
      // Slack covers counter load and output register
      check(n >= 508 && n <= 514, 1'b1, "wdt delay");
      check(flags.wdt_reset & flags.wdt_reset_en, 1'b1, "wdt flags");
      check(flags.pwr_on, 1'b0, "wdt set por");
      wait_for(0, 1'b0, 20, n);
      check(n >= 8 && n <= 9, 1'b1, "wdt hold");
      // Pin reset from idle keeps the watchdog flag
      power_control_register(1'b1, 1'b0);
      pin_reset();
      check(flags.wdt_reset, 1'b1, "ext reset flag");
      check(flags.pwr_on, 1'b0, "ext reset por");
      results();
   end
endmodule : power_mode_reset_sequencer_tb
